// >>> core/ppt_pkg.sv
// shared constants and types for the programmable pin and trigger block
package ppt_pkg;
  // pin and trigger modes
  typedef enum logic [1:0] {PIN_LOW, PIN_HIGH, PIN_PWM} ppt_pin_mode_e;
  typedef enum logic [1:0] {STATE_CHANGE_TRIGGER_MODE_OFF, STATE_CHANGE_TRIGGER_MODE_STATE, STATE_CHANGE_TRIGGER_MODE_EVERY} ppt_state_change_trigger_mode_mode_e;

  // bus geometry
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [5:0] OFF_PIN1_MODE = 6'h00;
  localparam logic [5:0] OFF_PIN1_COUNT = 6'h04;
  localparam logic [5:0] OFF_PIN1_DUTY = 6'h08;
  localparam logic [5:0] OFF_PIN1_PERIOD = 6'h0C;
  localparam logic [5:0] OFF_PIN2_MODE = 6'h10;
  localparam logic [5:0] OFF_STATE_CHANGE_TRIGGER_MODE_MODE = 6'h20;
  localparam logic [5:0] OFF_STATUS = 6'h24;

  // word index of the registers
  localparam logic [3:0] IDX_STATE_CHANGE_TRIGGER_MODE = 4'h8;
  localparam logic [3:0] IDX_STATUS = 4'h9;
  localparam logic [1:0] FLD_MODE = 2'h0;
  localparam logic [1:0] FLD_COUNT = 2'h1;
  localparam logic [1:0] FLD_DUTY = 2'h2;
  localparam logic [1:0] FLD_PERIOD = 2'h3;

  // field widths and limits
  localparam int COUNT_W = 14;
  localparam int CNTREG_W = 16;
  localparam int DUTY_W = 11;
  localparam int DUTY_SHIFT = 10;
  localparam int PERIOD_W = 12;
  localparam logic [31:0] COUNT_MAX = 32'h0000_270F;
  localparam logic [31:0] COUNT_ENDLESS32 = 32'hFFFF_FFFF;
  localparam logic [15:0] COUNT_ENDLESS = 16'hFFFF;
  localparam logic [31:0] DUTY_ONE = 32'h0000_0400;
  localparam logic [31:0] PERIOD_MAX = 32'h0000_0E10;
  localparam logic [31:0] MODE_LIMIT = 32'h0000_0003;

  // reset values
  localparam logic [15:0] RST_COUNT = 16'h0001;
  localparam logic [10:0] RST_DUTY = 11'h200;
  localparam logic [11:0] RST_PERIOD = 12'h3E8;

  // status bit positions
  localparam int ST_PIN1 = 0;
  localparam int ST_PIN2 = 1;
  localparam int ST_DONE1 = 2;
  localparam int ST_DONE2 = 3;
  localparam int ST_STATE_CHANGE_TRIGGER_MODE = 4;
  localparam int ST_SEQ = 5;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // timing
  localparam int CLK_PERIOD_NS = 32'h0000_0005;
  localparam int MS_NS = 32'h000F_4240;
  localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam int STATE_CHANGE_TRIGGER_MODE_PULSE_NS = 32'h0000_03E8;
  localparam int STATE_CHANGE_TRIGGER_MODE_CYC = (STATE_CHANGE_TRIGGER_MODE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STATE_CHANGE_TRIGGER_MODE_CNT_W = 8;
endpackage : ppt_pkg

// >>> core/ppt_pwm_pin.sv
// one programmable pin: constant level or counted pwm burst
`timescale 1ns/1ps
module ppt_pwm_pin #(
  parameter int CYC_PER_MS = ppt_pkg::CYC_PER_MS
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire ppt_pkg::ppt_pin_mode_e mode,
  input wire logic [ppt_pkg::COUNT_W-1:0] count,
  input wire logic endless,
  input wire logic [ppt_pkg::DUTY_W-1:0] duty,
  input wire logic [ppt_pkg::PERIOD_W-1:0] period,
  input wire logic restart,
  output logic pin_r,
  output logic done
);
  typedef enum logic {RUN, DONE} ppt_burst_e;

  ppt_burst_e st_r, st_nxt;
  logic [31:0] cycCnt_r, cycCnt_nxt;
  logic [ppt_pkg::COUNT_W-1:0] pulseCnt_r, pulseCnt_nxt;
  logic pin_nxt;
  logic [63:0] periodFull;
  logic [63:0] highFull;
  logic [31:0] periodCyc;
  logic [31:0] highCyc;

  // period and high time in clock cycles
  assign periodFull = 64'(period) * 64'(CYC_PER_MS);
  assign highFull = (periodFull * 64'(duty)) >> ppt_pkg::DUTY_SHIFT;
  assign periodCyc = periodFull[31:0];
  assign highCyc = highFull[31:0];
  assign done = (st_r == DONE);

  // burst sequencing and pin level
  always_comb
  begin
    st_nxt = st_r;
    cycCnt_nxt = cycCnt_r;
    pulseCnt_nxt = pulseCnt_r;
    if (restart)
    begin
      st_nxt = RUN;
      cycCnt_nxt = 32'h0000_0000;
      pulseCnt_nxt = '0;
    end
    else if (mode == ppt_pkg::PIN_PWM && st_r == RUN)
    begin
      if (cycCnt_r >= periodCyc - 32'h0000_0001)
      begin
        cycCnt_nxt = 32'h0000_0000;
        if (!endless)
        begin
          pulseCnt_nxt = pulseCnt_r + 1'b1;
          if (pulseCnt_nxt >= count)
          begin
            st_nxt = DONE;
          end
        end
      end
      else
      begin
        cycCnt_nxt = cycCnt_r + 32'h0000_0001;
      end
    end
    unique case (mode)
      ppt_pkg::PIN_HIGH: pin_nxt = 1'b1;
      ppt_pkg::PIN_PWM: pin_nxt = (st_nxt == RUN) && (cycCnt_nxt < highCyc);
      default: pin_nxt = 1'b0;
    endcase
  end

  // state registers
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r <= RUN;
      cycCnt_r <= 32'h0000_0000;
      pulseCnt_r <= '0;
      pin_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      cycCnt_r <= cycCnt_nxt;
      pulseCnt_r <= pulseCnt_nxt;
      pin_r <= pin_nxt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  high_level_a: assert property ((mode == ppt_pkg::PIN_HIGH) |=> pin_r || mode != ppt_pkg::PIN_HIGH)
    else $error("pin not high in high state");
  low_level_a: assert property ((mode == ppt_pkg::PIN_LOW) ##1 (mode == ppt_pkg::PIN_LOW) |-> !pin_r)
    else $error("pin not low in low state");
  done_rest_a: assert property ((st_r == DONE && !restart)[*2] |-> !pin_r || mode == ppt_pkg::PIN_HIGH)
    else $error("pin not resting low after burst");
  count_bound_a: assert property (!endless && st_r == RUN |-> pulseCnt_r < count || restart)
    else $error("pulse count exceeded");
  endless_run_a: assert property ((endless && st_r == RUN && !restart) |=> st_r == RUN)
    else $error("endless burst stopped");
  duty_shape_a: assert property ((mode == ppt_pkg::PIN_PWM && st_r == RUN && !restart) |=>
    (restart || st_r != RUN || mode != ppt_pkg::PIN_PWM || pin_r == (cycCnt_r < highCyc)))
    else $error("pwm level does not follow duty");
endmodule : ppt_pwm_pin

// >>> core/ppt_top.sv
// programmable pins and trigger output with an axi4-lite register slave
// Contract
// - each pin drives constant high, constant low or a pulse train according to its state.
// - in pwm state each pin's train uses that pin's own count, duty and period.
// - a finite burst produces exactly the programmed count of 1 to 9999 pulses, only in pwm state.
// - a count of minus one makes the pin pulse without end until reconfigured.
// - duty is a fraction from zero to one, one half giving half high time and one always high.
// - period is whole milliseconds from 1 to 3600 and is used only in pwm state.
// - the second pin has the same states and its own independent settings.
// - with the sequencer stopped and trigger mode off, no trigger is produced.
// - with the sequencer stopped and state-change mode, a trigger follows each output on/off change.
// - with the sequencer stopped and every-setting mode, a trigger follows each programmed output parameter.
// - with the sequencer running and state-change mode, triggers come only at enabled steps.
// - with the sequencer running and every-setting mode, a pulse follows every completed step.
// - with the sequencer running and trigger mode off, the trigger output stays inactive.
`timescale 1ns/1ps
module ppt_top #(
  parameter int CYC_PER_MS = ppt_pkg::CYC_PER_MS
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [ppt_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ppt_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ppt_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [ppt_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic seqRunning,
  input wire logic seqStepDone,
  input wire logic seqStepTrigEn,
  input wire logic outputOn,
  input wire logic paramProgrammed,
  output logic pinOne,
  output logic pinTwo,
  output logic trigOut
);
  logic rstMeta_b_r;
  logic rstSync_b_r;

  // reset release through two flops
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rstMeta_b_r <= 1'b0;
      rstSync_b_r <= 1'b0;
    end
    else
    begin
      rstMeta_b_r <= 1'b1;
      rstSync_b_r <= rstMeta_b_r;
    end
  end

  // configuration and bus state
  ppt_pkg::ppt_pin_mode_e pinMode_r [2];
  ppt_pkg::ppt_pin_mode_e pinMode_nxt [2];
  logic [ppt_pkg::CNTREG_W-1:0] pinCount_r [2];
  logic [ppt_pkg::CNTREG_W-1:0] pinCount_nxt [2];
  logic [ppt_pkg::DUTY_W-1:0] pinDuty_r [2];
  logic [ppt_pkg::DUTY_W-1:0] pinDuty_nxt [2];
  logic [ppt_pkg::PERIOD_W-1:0] pinPeriod_r [2];
  logic [ppt_pkg::PERIOD_W-1:0] pinPeriod_nxt [2];
  logic [1:0] restart_r, restart_nxt;
  ppt_pkg::ppt_state_change_trigger_mode_mode_e trigMode_r, trigMode_nxt;
  logic awHeld_r, awHeld_nxt;
  logic wHeld_r, wHeld_nxt;
  logic [ppt_pkg::ADDR_W-1:0] awAddr_r, awAddr_nxt;
  logic [ppt_pkg::DATA_W-1:0] wData_r, wData_nxt;
  logic [3:0] wStrb_r, wStrb_nxt;
  logic awready_r, awready_nxt;
  logic wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [ppt_pkg::DATA_W-1:0] rdata_r, rdata_nxt;
  logic [1:0] pinLevel;
  logic [1:0] pinDone;
  logic trigOut_r;

  // register index of a byte address
  function automatic logic [3:0] regIdx(input logic [ppt_pkg::ADDR_W-1:0] a);
    regIdx = a[5:2];
  endfunction : regIdx

  // write decode with range checks, read mux and handshakes
  always_comb
  begin
    logic [3:0] wi;
    logic [3:0] ri;
    logic ok;
    wi = regIdx(awAddr_r);
    ri = regIdx(araddr);
    ok = 1'b0;
    pinMode_nxt = pinMode_r;
    pinCount_nxt = pinCount_r;
    pinDuty_nxt = pinDuty_r;
    pinPeriod_nxt = pinPeriod_r;
    trigMode_nxt = trigMode_r;
    restart_nxt = 2'b00;
    awHeld_nxt = awHeld_r;
    wHeld_nxt = wHeld_r;
    awAddr_nxt = awAddr_r;
    wData_nxt = wData_r;
    wStrb_nxt = wStrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (awvalid && awready_r)
    begin
      awHeld_nxt = 1'b1;
      awAddr_nxt = awaddr;
    end
    if (wvalid && wready_r)
    begin
      wHeld_nxt = 1'b1;
      wData_nxt = wdata;
      wStrb_nxt = wstrb;
    end
    if (bvalid_r && bready)
    begin
      bvalid_nxt = 1'b0;
    end
    if (awHeld_r && wHeld_r && !bvalid_r)
    begin
      awHeld_nxt = 1'b0;
      wHeld_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      if (wStrb_r == 4'hF && wi < ppt_pkg::IDX_STATE_CHANGE_TRIGGER_MODE)
      begin
        unique case (wi[1:0])
          ppt_pkg::FLD_MODE:
            ok = wData_r < ppt_pkg::MODE_LIMIT;
          ppt_pkg::FLD_COUNT:
            ok = wData_r == ppt_pkg::COUNT_ENDLESS32 ||
              (wData_r != 32'h0000_0000 && wData_r <= ppt_pkg::COUNT_MAX);
          ppt_pkg::FLD_DUTY:
            ok = wData_r <= ppt_pkg::DUTY_ONE;
          ppt_pkg::FLD_PERIOD:
            ok = wData_r != 32'h0000_0000 && wData_r <= ppt_pkg::PERIOD_MAX;
        endcase
        if (ok)
        begin
          // settings of one pin restart only that pin
          restart_nxt[wi[2]] = 1'b1;
          unique case (wi[1:0])
            ppt_pkg::FLD_MODE: pinMode_nxt[wi[2]] = ppt_pkg::ppt_pin_mode_e'(wData_r[1:0]);
            ppt_pkg::FLD_COUNT: pinCount_nxt[wi[2]] = wData_r[ppt_pkg::CNTREG_W-1:0];
            ppt_pkg::FLD_DUTY: pinDuty_nxt[wi[2]] = wData_r[ppt_pkg::DUTY_W-1:0];
            ppt_pkg::FLD_PERIOD: pinPeriod_nxt[wi[2]] = wData_r[ppt_pkg::PERIOD_W-1:0];
          endcase
        end
      end
      else if (wStrb_r == 4'hF && wi == ppt_pkg::IDX_STATE_CHANGE_TRIGGER_MODE && wData_r < ppt_pkg::MODE_LIMIT)
      begin
        ok = 1'b1;
        trigMode_nxt = ppt_pkg::ppt_state_change_trigger_mode_mode_e'(wData_r[1:0]);
      end
      bresp_nxt = ok ? ppt_pkg::RESP_OKAY : ppt_pkg::RESP_SLVERR;
    end
    awready_nxt = !awHeld_nxt;
    wready_nxt = !wHeld_nxt;
    if (rvalid_r && rready)
    begin
      rvalid_nxt = 1'b0;
    end
    if (arvalid && arready_r)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt = ppt_pkg::RESP_OKAY;
      rdata_nxt = 32'h0000_0000;
      if (ri < ppt_pkg::IDX_STATE_CHANGE_TRIGGER_MODE)
      begin
        unique case (ri[1:0])
          ppt_pkg::FLD_MODE: rdata_nxt = 32'(pinMode_r[ri[2]]);
          ppt_pkg::FLD_COUNT: rdata_nxt = 32'(signed'(pinCount_r[ri[2]]));
          ppt_pkg::FLD_DUTY: rdata_nxt = 32'(pinDuty_r[ri[2]]);
          ppt_pkg::FLD_PERIOD: rdata_nxt = 32'(pinPeriod_r[ri[2]]);
        endcase
      end
      else if (ri == ppt_pkg::IDX_STATE_CHANGE_TRIGGER_MODE)
      begin
        rdata_nxt = 32'(trigMode_r);
      end
      else if (ri == ppt_pkg::IDX_STATUS)
      begin
        rdata_nxt[ppt_pkg::ST_PIN1] = pinLevel[0];
        rdata_nxt[ppt_pkg::ST_PIN2] = pinLevel[1];
        rdata_nxt[ppt_pkg::ST_DONE1] = pinDone[0];
        rdata_nxt[ppt_pkg::ST_DONE2] = pinDone[1];
        rdata_nxt[ppt_pkg::ST_STATE_CHANGE_TRIGGER_MODE] = trigOut_r;
        rdata_nxt[ppt_pkg::ST_SEQ] = seqRunning;
      end
      else
      begin
        rresp_nxt = ppt_pkg::RESP_SLVERR;
      end
    end
    arready_nxt = !rvalid_nxt;
  end

  // configuration and bus registers
  always_ff @(posedge clk or negedge rstSync_b_r)
  begin
    if (!rstSync_b_r)
    begin
      for (int i = 0; i < 2; i++)
      begin
        pinMode_r[i] <= ppt_pkg::PIN_LOW;
        pinCount_r[i] <= ppt_pkg::RST_COUNT;
        pinDuty_r[i] <= ppt_pkg::RST_DUTY;
        pinPeriod_r[i] <= ppt_pkg::RST_PERIOD;
      end
      trigMode_r <= ppt_pkg::STATE_CHANGE_TRIGGER_MODE_OFF;
      restart_r <= 2'b00;
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= '0;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= ppt_pkg::RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= ppt_pkg::RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      pinMode_r <= pinMode_nxt;
      pinCount_r <= pinCount_nxt;
      pinDuty_r <= pinDuty_nxt;
      pinPeriod_r <= pinPeriod_nxt;
      trigMode_r <= trigMode_nxt;
      restart_r <= restart_nxt;
      awHeld_r <= awHeld_nxt;
      wHeld_r <= wHeld_nxt;
      awAddr_r <= awAddr_nxt;
      wData_r <= wData_nxt;
      wStrb_r <= wStrb_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rresp = rresp_r;
  assign rdata = rdata_r;

  // two independent pin generators
  generate
    for (genvar g = 0; g < 2; g++)
    begin : genPin
      ppt_pwm_pin #(
        .CYC_PER_MS(CYC_PER_MS)
      ) uPin (
        .clk(clk),
        .rst_b(rstSync_b_r),
        .mode(pinMode_r[g]),
        .count(pinCount_r[g][ppt_pkg::COUNT_W-1:0]),
        .endless(pinCount_r[g] == ppt_pkg::COUNT_ENDLESS),
        .duty(pinDuty_r[g]),
        .period(pinPeriod_r[g]),
        .restart(restart_r[g]),
        .pin_r(pinLevel[g]),
        .done(pinDone[g])
      );
    end
  endgenerate

  assign pinOne = pinLevel[0];
  assign pinTwo = pinLevel[1];

  // trigger event selection
  function automatic logic trigFire(input ppt_pkg::ppt_state_change_trigger_mode_mode_e m, input logic run, input logic chg,
    input logic prog, input logic step, input logic stepEn);
    unique case (m)
      ppt_pkg::STATE_CHANGE_TRIGGER_MODE_STATE: trigFire = run ? (step && stepEn) : chg;
      ppt_pkg::STATE_CHANGE_TRIGGER_MODE_EVERY: trigFire = run ? step : prog;
      default: trigFire = 1'b0;
    endcase
  endfunction : trigFire

  logic onPrev_r, onPrev_nxt;
  logic [ppt_pkg::STATE_CHANGE_TRIGGER_MODE_CNT_W-1:0] trigCnt_r, trigCnt_nxt;
  logic trigOut_nxt;
  logic fire;

  // trigger pulse stretcher, retriggered by each event
  always_comb
  begin
    onPrev_nxt = outputOn;
    fire = trigFire(trigMode_r, seqRunning, outputOn != onPrev_r, paramProgrammed, seqStepDone, seqStepTrigEn);
    trigCnt_nxt = trigCnt_r;
    if (fire)
    begin
      trigCnt_nxt = ppt_pkg::STATE_CHANGE_TRIGGER_MODE_CNT_W'(ppt_pkg::STATE_CHANGE_TRIGGER_MODE_CYC);
    end
    else if (trigCnt_r != '0)
    begin
      trigCnt_nxt = trigCnt_r - 1'b1;
    end
    trigOut_nxt = trigCnt_nxt != '0;
  end

  // trigger registers
  always_ff @(posedge clk or negedge rstSync_b_r)
  begin
    if (!rstSync_b_r)
    begin
      onPrev_r <= 1'b0;
      trigCnt_r <= '0;
      trigOut_r <= 1'b0;
    end
    else
    begin
      onPrev_r <= onPrev_nxt;
      trigCnt_r <= trigCnt_nxt;
      trigOut_r <= trigOut_nxt;
    end
  end

  assign trigOut = trigOut_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSync_b_r);

  state_change_trigger_mode_off_quiet_a: assert property ((trigMode_r == ppt_pkg::STATE_CHANGE_TRIGGER_MODE_OFF && !trigOut_r) |=> !trigOut_r)
    else $error("trigger produced in off mode");
  state_change_a: assert property ((trigMode_r == ppt_pkg::STATE_CHANGE_TRIGGER_MODE_STATE && !seqRunning && outputOn != onPrev_r)
    |=> trigOut_r && trigCnt_r == ppt_pkg::STATE_CHANGE_TRIGGER_MODE_CNT_W'(ppt_pkg::STATE_CHANGE_TRIGGER_MODE_CYC))
    else $error("no trigger on output state change");
  every_setting_a: assert property ((trigMode_r == ppt_pkg::STATE_CHANGE_TRIGGER_MODE_EVERY && !seqRunning && paramProgrammed)
    |=> trigOut_r)
    else $error("no trigger on parameter write");
  step_gated_a: assert property ((trigMode_r == ppt_pkg::STATE_CHANGE_TRIGGER_MODE_STATE && seqRunning && !trigOut_r
    && !(seqStepDone && seqStepTrigEn)) |=> !trigOut_r)
    else $error("trigger at a disabled step");
  step_done_a: assert property ((trigMode_r == ppt_pkg::STATE_CHANGE_TRIGGER_MODE_EVERY && seqRunning && seqStepDone)
    |=> trigOut_r)
    else $error("no pulse at step completion");
  bresp_hold_a: assert property ((bvalid_r && !bready) |=> bvalid_r && $stable(bresp_r))
    else $error("write response dropped");
  bad_count_a: assert property ((awHeld_r && wHeld_r && !bvalid_r && wStrb_r == 4'hF
    && regIdx(awAddr_r) == 4'h1 && wData_r == 32'h0000_0000) |=> bresp_r == ppt_pkg::RESP_SLVERR)
    else $error("zero count accepted");
endmodule : ppt_top

// >>> tb/ppt_far_end.sv
// far-end equipment model: counts pulses on the two pins and the trigger line
`timescale 1ns/1ps
module ppt_far_end (
  input wire logic clk,
  input wire logic clr,
  input wire logic [2:0] lines,
  output int rise [3],
  output int width [3]
);
  int run [3];
  logic [2:0] last;

  // count rising edges and keep the width in cycles of the last finished high pulse
  always @(posedge clk)
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (clr)
      begin
        rise[i] = 0;
        width[i] = 0;
        run[i] = 0;
      end
      else if (lines[i] === 1'b1)
      begin
        rise[i] = rise[i] + ((last[i] === 1'b1) ? 0 : 1);
        run[i] = run[i] + 1;
      end
      else if (last[i] === 1'b1)
      begin
        width[i] = run[i];
        run[i] = 0;
      end
    end
    last <= lines;
  end
endmodule : ppt_far_end

// >>> tb/prog_pin_pulse_and_trigger_out_bench.sv
// self-checking bench for the programmable pins and trigger output
`timescale 1ns/1ps
`define CK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s exp %0h seen %0h", nm, e, g); end end
module prog_pin_pulse_and_trigger_out_bench;
  localparam int CPM = 20;
  localparam logic [1:0] OK = ppt_pkg::RESP_OKAY;
  localparam logic [1:0] ER = ppt_pkg::RESP_SLVERR;
  logic clk, rst_b, awvalid, wvalid, bready, arvalid, rready, clr;
  logic seqRunning, seqStepDone, seqStepTrigEn, outputOn, paramProgrammed;
  logic awready, wready, bvalid, arready, rvalid, pinOne, pinTwo, trigOut;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int n_mismatch = 0;
  int checks = 0;
  int seed = 18317;
  int rise [3];
  int width [3];
  int cnt, per, duty, ex;
  logic [5:0] ra [6] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h20, 6'h24};
  logic [31:0] rv [6] = '{32'h0000_0000, 32'h0000_0001, 32'h0000_0200, 32'h0000_03E8, 32'h0000_0000, 32'h0000_0000};
  logic [5:0] ta [11] = '{6'h04, 6'h04, 6'h08, 6'h0C, 6'h0C, 6'h24, 6'h28, 6'h04, 6'h0C, 6'h08, 6'h00};
  logic [31:0] td [11] = '{32'h0000_0000, 32'h0000_2710, 32'h0000_0401, 32'h0000_0000, 32'h0000_0E11,
    32'h0000_0000, 32'h0000_0000, 32'h0000_270F, 32'h0000_0E10, 32'h0000_0400, 32'h0000_0003};
  logic [1:0] tr [11] = '{ER, ER, ER, ER, ER, ER, ER, OK, OK, OK, ER};

  ppt_top #(.CYC_PER_MS(CPM)) dut_u (.clk(clk), .rst_b(rst_b), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .seqRunning(seqRunning), .seqStepDone(seqStepDone), .seqStepTrigEn(seqStepTrigEn),
    .outputOn(outputOn), .paramProgrammed(paramProgrammed), .pinOne(pinOne), .pinTwo(pinTwo), .trigOut(trigOut));

  ppt_far_end far_u (.clk(clk), .clr(clr), .lines({trigOut, pinTwo, pinOne}), .rise(rise), .width(width));

  // 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // bus write: address and data offered together, each released when taken
  task automatic wr(input logic [5:0] a, input logic [31:0] v, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (!bvalid && n < 1000);
    // a write answer that never comes counts as a mismatch
    if (!bvalid) n_mismatch++;
    bready <= 1'b0;
    `CK("bresp", er, bresp)
  endtask : wr

  // bus read: result handed back in q
  task automatic rd(input logic [5:0] a, output logic [31:0] q, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end
    while (!rvalid && n < 1000);
    // a read answer that never comes counts as a mismatch
    if (!rvalid) n_mismatch++;
    rready <= 1'b0;
    q = rdata;
    `CK("rresp", er, rresp)
  endtask : rd

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // restart the far-end counters
  task automatic clear;
    clr <= 1'b1;
    tick(1);
    clr <= 1'b0;
  endtask : clear

  task automatic conclude;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  // watchdog against a hung handshake
  initial
  begin
    #250000;
    n_mismatch++;
    conclude();
  end

  // main sequence
  initial
  begin
    {rst_b, awvalid, wvalid, bready, arvalid, rready, seqRunning, seqStepDone} = 8'h00;
    {seqStepTrigEn, outputOn, paramProgrammed} = 3'h0;
    {awaddr, araddr, wdata} = 44'h000_0000_0000;
    wstrb = 4'hF;
    clr = 1'b1;
    tick(10);
    rst_b <= 1'b1;
    clr <= 1'b0;
    // reset values of pin one and the trigger mode
    for (int i = 0; i < 6; i++)
    begin
      rd(ra[i], d, OK);
      `CK("reset value", rv[i], d)
    end
    // out-of-range values, read-only and unmapped places, and the accepted limits
    for (int i = 0; i < 11; i++)
      wr(ta[i], td[i], tr[i]);
    // a partial word write is refused and leaves the count alone
    wstrb <= 4'h3;
    wr(6'h04, 32'h0000_0005, ER);
    wstrb <= 4'hF;
    rd(6'h28, d, ER);
    rd(6'h04, d, OK);
    `CK("count limit", 32'h0000_270F, d)
    rd(6'h0C, d, OK);
    `CK("period limit", 32'h0000_0E10, d)
    // constant levels on both pins in every combination
    for (int v = 0; v < 4; v++)
    begin
      wr(6'h00, 32'(v & 1), OK);
      wr(6'h10, 32'((v >> 1) & 1), OK);
      tick(2);
      #1;
      `CK("pinOne level", 1'(v), pinOne)
      `CK("pinTwo level", 1'(v >> 1), pinTwo)
    end
    wr(6'h00, 32'h0000_0000, OK);
    wr(6'h10, 32'h0000_0000, OK);
    // finite random bursts, one pin at a time
    for (int p = 0; p < 2; p++)
    begin
      cnt = 2 + $unsigned($random(seed)) % 3;
      per = 1 + $unsigned($random(seed)) % 2;
      duty = 128 + $unsigned($random(seed)) % 768;
      wr(6'(p * 16 + 4), 32'(cnt), OK);
      wr(6'(p * 16 + 8), 32'(duty), OK);
      wr(6'(p * 16 + 12), 32'(per), OK);
      clear();
      wr(6'(p * 16), 32'h0000_0002, OK);
      tick(cnt * per * CPM + 10);
      #1;
      `CK("pulse count", cnt, rise[p])
      `CK("high width", per * CPM * duty / 1024, width[p])
      `CK("other pin idle", 0, rise[1 - p])
      `CK("rest level", 1'b0, p ? pinTwo : pinOne)
      rd(6'h24, d, OK);
      `CK("done flags", 32'((1 << ppt_pkg::ST_DONE1) | (p << ppt_pkg::ST_DONE2)), d)
    end
    // endless burst on pin two, then full and zero duty
    wr(6'h14, 32'hFFFF_FFFF, OK);
    wr(6'h18, 32'h0000_0200, OK);
    wr(6'h1C, 32'h0000_0001, OK);
    clear();
    wr(6'h10, 32'h0000_0002, OK);
    tick(205);
    #1;
    `CK("endless pulses", 1'b1, rise[1] >= 10)
    rd(6'h14, d, OK);
    `CK("endless count", 32'hFFFF_FFFF, d)
    wr(6'h18, 32'h0000_0400, OK);
    tick(3);
    clear();
    tick(100);
    #1;
    `CK("full duty", 1'b1, pinTwo)
    `CK("full duty edges", 0, rise[1])
    wr(6'h18, 32'h0000_0000, OK);
    tick(3);
    #1;
    `CK("zero duty", 1'b0, pinTwo)
    wr(6'h10, 32'h0000_0000, OK);
    // every trigger mode against every event, sequencer stopped and running
    for (int m = 0; m < 3; m++)
    begin
      wr(6'h20, 32'(m), OK);
      for (int s = 0; s < 2; s++)
        for (int ev = 0; ev < 3; ev++)
        begin
          @(posedge clk);
          seqRunning <= 1'(s);
          seqStepTrigEn <= 1'($random(seed));
          tick(210);
          clear();
          paramProgrammed <= (ev == 0);
          seqStepDone <= (ev == 2);
          if (ev == 1) outputOn <= ~outputOn;
          tick(1);
          paramProgrammed <= 1'b0;
          seqStepDone <= 1'b0;
          tick(210);
          #1;
          ex = (m == 0) ? 0 : (s == 0) ? ((m == 1) ? (ev == 1) : (ev == 0)) : (ev == 2 && (m == 2 || seqStepTrigEn));
          `CK("trigger count", ex, rise[2])
          if (ex != 0) `CK("trigger width", ppt_pkg::STATE_CHANGE_TRIGGER_MODE_CYC, width[2])
        end
    end
    conclude();
  end
endmodule : prog_pin_pulse_and_trigger_out_bench
